// ===== verilog/urxdma_params.svh
// Offsets, field positions and reset values of the receive DMA channel.
// Assumes inclusion by bare name from the channel and its package users.
`ifndef URXDMA_PARAMS_SVH
`define URXDMA_PARAMS_SVH
// Register offsets in the mapped register space
`define URX_OFF_CTRL    4'h0
`define URX_OFF_SEG     4'h1
`define URX_OFF_BASE    4'h2
`define URX_OFF_BOUND   4'h3
`define URX_OFF_PTR     4'h4
`define URX_OFF_COUNT   4'h5
`define URX_OFF_FSTAT   4'h6
`define URX_OFF_FDATA   4'h7
`define URX_OFF_TOUT    4'h8
`define URX_OFF_GFLAGS  4'h9
// Control register fields
`define URX_CTRL_RUN    0
`define URX_CTRL_MODE_L 1
`define URX_CTRL_CIRC   3
`define URX_CTRL_IE     4
// FIFO status fields
`define URX_FST_EMPTY   0
`define URX_FST_FULL    1
`define URX_FST_ORDER   7
// Reset values
`define URX_RST_BYTE    8'h00
`define URX_RST_WORD    16'h0000
// Data FIFO depth in bytes
`define URX_FIFO_DEPTH  4
// Timeout tick prescale in clk_sys cycles
`define URX_TICK_DIV    16
`endif

// ===== verilog/urxdma_pkg.sv
// Types shared by the receive DMA channel.
// Assumes nothing beyond a SystemVerilog compiler.
package urxdma_pkg;
  // Receive interrupt modes held in the control register
  typedef enum logic [1:0] {
    URXDMA_NOIRQ    = 2'h0,
    URXDMA_PERIODIC = 2'h1,
    URXDMA_TIMEOUT  = 2'h2
  } urxdma_mode_t;
  // Channel activity
  typedef enum logic {URXDMA_IDLE, URXDMA_RUN} urxdma_state_t;
endpackage

// ===== verilog/urxdma_fifo.sv
// Small valid/ready byte FIFO between the UART and the memory writer.
// Assumes both sides on clk_sys with synchronous active-high reset.
module urxdma_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic             push;
  logic             pop;

  // Honest handshakes from the fill level
  assign inReady  = level != (AW+1)'(DEPTH);
  assign outValid = level != '0;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr];

  // Storage write
  always_ff @(posedge clk_sys) begin
    if (push) mem[wrPtr] <= inData;
  end

  // Pointers and level
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end else begin
      if (push) wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      if (pop) rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      level <= level + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge clk_sys) disable iff (rst)
    level <= (AW+1)'(DEPTH)) else $error("fifo level over depth");
endmodule // urxdma_fifo

// ===== verilog/urxdma_channel.sv
// One receive DMA channel serving a single UART receiver.
// Assumes UART and memory port on clk_sys, registers on a simple
// mapped register port with one-cycle write and combinational read.
`include "urxdma_params.svh"
module urxdma_channel #(
  parameter int          CHAN    = 0,
  parameter int          TICKDIV = `URX_TICK_DIV,
  parameter int          FDEPTH  = `URX_FIFO_DEPTH
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Mapped register port
  input  wire logic [3:0]  regAddr,
  input  wire logic        regWrite,
  input  wire logic [15:0] regWdata,
  output logic      [15:0] regRdata,
  // Dedicated UART receiver stream
  input  wire logic        rxValid,
  output logic             rxReady,
  input  wire logic [7:0]  rxData,
  // External memory write port
  output logic             memReq,
  output logic      [23:0] memAddr,
  output logic      [7:0]  memData,
  input  wire logic        memAck,
  // Maskable interrupt request to the controller
  output logic             dmaIrq
);
  localparam int LW = $clog2(FDEPTH) + 1;
  localparam int TW = $clog2(TICKDIV + 1);

  // Register state
  logic [7:0]  ctrl;
  logic [7:0]  segment;
  logic [7:0]  baseHigh;
  logic [7:0]  boundHigh;
  logic [15:0] pointer;
  logic [15:0] byteCount;
  logic [7:0]  toutReload;
  logic [15:0] gflags;
  // Internal counters
  logic [15:0] byteCounter;
  logic [7:0]  toutCount;
  logic        toutArmed;
  logic [TW-1:0] tickCount;
  urxdma_pkg::urxdma_state_t state;

  // Pointer step with circular wrap at the bound
  function automatic logic [15:0] stepPtr(input logic [15:0] p,
                                          input logic        circ,
                                          input logic [7:0]  bnd,
                                          input logic [7:0]  bas);
    logic [15:0] n;
    n = p + 16'h0001;
    if (circ && n == {bnd, 8'h00}) n = {bas, 8'h00};
    return n;
  endfunction

  // Decoded control fields
  wire                         runBit  = ctrl[`URX_CTRL_RUN];
  wire                         circBit = ctrl[`URX_CTRL_CIRC];
  wire                         ieBit   = ctrl[`URX_CTRL_IE];
  wire urxdma_pkg::urxdma_mode_t mode  =
    urxdma_pkg::urxdma_mode_t'(ctrl[`URX_CTRL_MODE_L +: 2]);
  wire isPeriodic = mode == urxdma_pkg::URXDMA_PERIODIC;
  wire isTimeout  = mode == urxdma_pkg::URXDMA_TIMEOUT;

  // Register write strobes
  wire wCtrl  = regWrite && regAddr == `URX_OFF_CTRL;
  wire wSeg   = regWrite && regAddr == `URX_OFF_SEG;
  wire wBase  = regWrite && regAddr == `URX_OFF_BASE;
  wire wBound = regWrite && regAddr == `URX_OFF_BOUND;
  wire wPtr   = regWrite && regAddr == `URX_OFF_PTR;
  wire wCount = regWrite && regAddr == `URX_OFF_COUNT;
  wire wTout  = regWrite && regAddr == `URX_OFF_TOUT;
  wire wFlags = regWrite && regAddr == `URX_OFF_GFLAGS;

  // FIFO in the data path
  logic          fOutValid;
  logic [7:0]    fOutData;
  logic [LW-1:0] fLevel;
  logic          fifoInReady;
  wire           rxTake = rxValid && rxReady;
  wire           memDone = memReq && memAck;

  urxdma_fifo #(
    .WIDTH (8),
    .DEPTH (FDEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inValid  (rxValid && state == urxdma_pkg::URXDMA_RUN),
    .inReady  (fifoInReady),
    .inData   (rxData),
    .outValid (fOutValid),
    .outReady (memAck && state == urxdma_pkg::URXDMA_RUN),
    .outData  (fOutData),
    .level    (fLevel)
  );

  // Memory side handshake and address
  assign rxReady = fifoInReady && state == urxdma_pkg::URXDMA_RUN;
  assign memReq  = fOutValid && state == urxdma_pkg::URXDMA_RUN;
  assign memAddr = {segment, pointer};
  assign memData = fOutData;

  // Event decode
  wire periodicHit = memDone && isPeriodic && byteCounter <= 16'h0001;
  wire tickNow     = tickCount == TW'(TICKDIV - 1);
  wire toutZero    = toutArmed && tickNow && toutCount == 8'h01 &&
                     !rxTake;
  wire toutExpire  = isTimeout && toutZero;
  wire [3:0] flagIdx = 4'(2 * CHAN);

  // Interrupt: own two flags gated by enable, not by the mode
  assign dmaIrq = ieBit && (gflags[flagIdx] || gflags[flagIdx + 4'h1]);

  // Read mux
  wire fEmpty = fLevel == '0;
  wire fFull  = fLevel == LW'(FDEPTH);
  always_comb begin
    regRdata = 16'h0000;
    case (regAddr)
      `URX_OFF_CTRL:   regRdata = {8'h00, ctrl};
      `URX_OFF_SEG:    regRdata = {8'h00, segment};
      `URX_OFF_BASE:   regRdata = {8'h00, baseHigh};
      `URX_OFF_BOUND:  regRdata = {8'h00, boundHigh};
      `URX_OFF_PTR:    regRdata = pointer;
      `URX_OFF_COUNT:  regRdata = byteCount;
      `URX_OFF_FSTAT:  regRdata = {8'h00, 1'b0, 4'(fLevel), 1'b0,
                                   fFull, fEmpty};
      `URX_OFF_FDATA:  regRdata = {8'h00, fOutData};
      `URX_OFF_TOUT:   regRdata = {8'h00, toutReload};
      `URX_OFF_GFLAGS: regRdata = gflags;
      default:         regRdata = 16'h0000;
    endcase
  end

  // Control and plain registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl       <= `URX_RST_BYTE;
      segment    <= `URX_RST_BYTE;
      baseHigh   <= `URX_RST_BYTE;
      boundHigh  <= `URX_RST_BYTE;
      byteCount  <= `URX_RST_WORD;
      toutReload <= `URX_RST_BYTE;
    end else begin
      if (wCtrl)  ctrl <= regWdata[7:0];
      if (wSeg)   segment <= regWdata[7:0];
      if (wBase)  baseHigh <= regWdata[7:0];
      if (wBound) boundHigh <= regWdata[7:0];
      if (wCount) byteCount <= regWdata;
      if (wTout)  toutReload <= regWdata[7:0];
    end
  end

  // Run state follows run bit only
  always_ff @(posedge clk_sys) begin
    if (rst) state <= urxdma_pkg::URXDMA_IDLE;
    else begin
      case (state)
        urxdma_pkg::URXDMA_IDLE:
          if (runBit) state <= urxdma_pkg::URXDMA_RUN;
        urxdma_pkg::URXDMA_RUN:
          if (!runBit) state <= urxdma_pkg::URXDMA_IDLE;
        default: state <= urxdma_pkg::URXDMA_IDLE;
      endcase
    end
  end

  // Address pointer advances per stored byte
  always_ff @(posedge clk_sys) begin
    if (rst) pointer <= `URX_RST_WORD;
    else if (memDone)
      pointer <= stepPtr(pointer, circBit, boundHigh, baseHigh);
    else if (wPtr) pointer <= regWdata;
  end

  // Byte counter spaces periodic interrupts
  always_ff @(posedge clk_sys) begin
    if (rst) byteCounter <= `URX_RST_WORD;
    else if (wCount) byteCounter <= regWdata;
    else if (periodicHit) byteCounter <= byteCount;
    else if (memDone && isPeriodic) byteCounter <= byteCounter - 16'h0001;
  end

  // Timeout prescaler and countdown
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tickCount <= '0;
      toutCount <= `URX_RST_BYTE;
      toutArmed <= 1'b0;
    end else begin
      tickCount <= tickNow ? '0 : tickCount + 1'b1;
      if (rxTake) begin
        toutCount <= toutReload;
        toutArmed <= toutReload != 8'h00;
        tickCount <= '0;
      end else if (toutZero) begin
        toutCount <= 8'h00;
        toutArmed <= 1'b0;
      end else if (toutArmed && tickNow)
        toutCount <= toutCount - 8'h01;
    end
  end

  // Global flags: hardware set wins over software write
  always_ff @(posedge clk_sys) begin
    if (rst) gflags <= `URX_RST_WORD;
    else begin
      if (wFlags) gflags <= regWdata;
      if (periodicHit) gflags[flagIdx] <= 1'b1;
      if (toutExpire) gflags[flagIdx + 4'h1] <= 1'b1;
    end
  end

  // Checks
  addr_form_a: assert property (@(posedge clk_sys) disable iff (rst)
    memAddr[23:16] == segment && memAddr[15:0] == pointer)
    else $error("memory address not segment over pointer");
  ptr_step_a: assert property (@(posedge clk_sys) disable iff (rst)
    memDone |=> pointer == stepPtr($past(pointer), $past(circBit),
      $past(boundHigh), $past(baseHigh)))
    else $error("pointer did not step");
  ptr_wrap_a: assert property (@(posedge clk_sys) disable iff (rst)
    memDone && circBit && pointer + 16'h1 == {boundHigh, 8'h00}
    |=> pointer == {$past(baseHigh), 8'h00})
    else $error("pointer did not wrap to base");
  per_reload_a: assert property (@(posedge clk_sys) disable iff (rst)
    periodicHit && !wCount |=> byteCounter == $past(byteCount) &&
    gflags[flagIdx])
    else $error("counter not reloaded with flag");
  noirq_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
    mode == urxdma_pkg::URXDMA_NOIRQ && !wFlags
    |=> $stable(gflags))
    else $error("flag set in no-interrupt mode");
  tout_load_a: assert property (@(posedge clk_sys) disable iff (rst)
    rxTake && !wTout |=> toutCount == $past(toutReload))
    else $error("countdown not reloaded on character");
  tout_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
    toutExpire |=> gflags[flagIdx + 4'h1] && !toutArmed)
    else $error("timeout expiry not flagged");
  run_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    state == urxdma_pkg::URXDMA_RUN && runBit
    |=> state == urxdma_pkg::URXDMA_RUN)
    else $error("channel stopped without command");
  irq_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    !ieBit |-> !dmaIrq)
    else $error("interrupt while disabled");
  stat_full_a: assert property (@(posedge clk_sys) disable iff (rst)
    fFull |-> !rxReady && !fEmpty)
    else $error("full FIFO still ready");

  // Idle channel neither takes nor stores bytes
  idle_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    state != urxdma_pkg::URXDMA_RUN |-> !rxReady && !memReq)
    else $error("idle channel moved data");
  // In periodic mode the byte counter steps once per stored byte
  cnt_step_a: assert property (@(posedge clk_sys) disable iff (rst)
    memDone && isPeriodic && !periodicHit && !wCount
    |=> byteCounter == $past(byteCounter) - 16'h0001)
    else $error("byte counter did not step");
  // Periodic flag rises only on the counted byte
  per_only_a: assert property (@(posedge clk_sys) disable iff (rst)
    !gflags[flagIdx] && !periodicHit && !wFlags
    |=> !gflags[flagIdx])
    else $error("periodic flag without count");
  // Pointer holds between transfers and writes
  ptr_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !memDone && !wPtr |=> $stable(pointer))
    else $error("pointer moved without transfer");
  // Countdown steps once per prescaled tick
  tout_tick_a: assert property (@(posedge clk_sys) disable iff (rst)
    toutArmed && tickNow && !rxTake && !toutZero
    |=> toutCount == $past(toutCount) - 8'h01)
    else $error("countdown did not step");
  // Zero reload leaves the countdown off
  tout_disarm_a: assert property (@(posedge clk_sys) disable iff (rst)
    rxTake && toutReload == 8'h00 && !wTout |=> !toutArmed)
    else $error("zero reload armed the countdown");
  // Software clear sticks unless hardware sets again
  flag_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    wFlags && !regWdata[flagIdx] && !periodicHit
    |=> !gflags[flagIdx])
    else $error("periodic flag not cleared");
  // Enabled timeout flag reaches the request line
  irq_level_a: assert property (@(posedge clk_sys) disable iff (rst)
    ieBit && gflags[flagIdx + 4'h1] |-> dmaIrq)
    else $error("enabled flag not requested");
  // Taken byte is offered to memory next cycle
  rx_store_a: assert property (@(posedge clk_sys) disable iff (rst)
    rxTake && runBit |=> memReq)
    else $error("taken byte not offered");

  per_irq_c: cover property (@(posedge clk_sys) periodicHit);
  tout_irq_c: cover property (@(posedge clk_sys) toutExpire);
  wrap_c: cover property (@(posedge clk_sys)
    memDone && circBit && pointer + 16'h1 == {boundHigh, 8'h00});
  full_c: cover property (@(posedge clk_sys) fFull);
  store_c: cover property (@(posedge clk_sys)
    memDone && mode == urxdma_pkg::URXDMA_NOIRQ);
endmodule // urxdma_channel

// ===== bench/urxdma_far_end.sv
// Far-side model: UART byte source and external memory that accepts writes.
// Assumes clk_sys rising-edge timing; the bench feeds bytes through push.
module urxdma_far_end (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        memStall,
  output logic             rxValid,
  input  wire logic        rxReady,
  output logic      [7:0]  rxData,
  input  wire logic        memReq,
  input  wire logic [23:0] memAddr,
  input  wire logic [7:0]  memData,
  output logic             memAck
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  sendQ[$];
  logic [31:0] logQ[$];
  initial begin
    rxValid = 1'b0;
    rxData  = 8'h00;
    memAck  = 1'b0;
  end
  task automatic push(input logic [7:0] b);
    sendQ.push_back(b);
  endtask
  // Offer bytes in order, hold until taken, scramble data when idle
  always @(posedge clk_sys) begin
    if (rxValid && rxReady && !rst) begin
      void'(sendQ.pop_front());
    end
    if (!rst && sendQ.size() > 0) begin
      rxValid <= 1'b1;
      rxData  <= sendQ[0];
    end else begin
      rxValid <= 1'b0;
      rxData  <= ~rxData;
    end
  end
  // Log accepted writes; acknowledge every other cycle unless stalled
  always @(posedge clk_sys) begin
    if (memReq && memAck && !rst) begin
      logQ.push_back({memAddr, memData});
    end
    memAck <= !rst && memReq && !memAck && !memStall;
  end
endmodule // urxdma_far_end

// ===== bench/uart_rx_dma_channel_bench.sv
// Self-checking bench for one receive DMA channel and its far-side model.
// Assumes a 100 ns clk_sys and the register indices of the channel.
module uart_rx_dma_channel_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys  = 1'b0;
  logic        rst;
  logic        regWrite;
  logic        memStall;
  logic [3:0]  regAddr;
  logic [15:0] regWdata;
  logic [15:0] regRdata;
  logic        rxValid, rxReady, memReq, memAck, dmaIrq;
  logic [7:0]  rxData, memData;
  logic [23:0] memAddr;
  int          error_cnt = 0;
  int          checks    = 0;
  int          k, n;
  logic [3:0]  regs[7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9};
  logic [15:0] vals[7] = '{16'h005a, 16'h00a5, 16'h003c, 16'hbeef,
                           16'h0081, 16'h0077, 16'ha5a5};
  logic [15:0] pa[5]   = '{16'h40fe, 16'h40ff, 16'h4000, 16'h4001, 16'h4002};

  urxdma_channel #(.TICKDIV(2)) dut (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(regRdata), .rxValid(rxValid),
    .rxReady(rxReady), .rxData(rxData), .memReq(memReq),
    .memAddr(memAddr), .memData(memData), .memAck(memAck), .dmaIrq(dmaIrq));
  urxdma_far_end far (
    .clk_sys(clk_sys), .rst(rst), .memStall(memStall), .rxValid(rxValid),
    .rxReady(rxReady), .rxData(rxData), .memReq(memReq),
    .memAddr(memAddr), .memData(memData), .memAck(memAck));

  // Free-running clock
  always #50 clk_sys = ~clk_sys;

  task automatic test_done;
    $display("Counts: %0d checks, %0d errors", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    @(negedge clk_sys);
    check({16'h0000, regRdata}, {16'h0000, e});
  endtask
  // Bounded wait until the memory log holds n writes
  task automatic waitLog(input int cnt);
    int i;
    for (i = 0; i < 300 && far.logQ.size() < cnt; i++) @(posedge clk_sys);
    if (far.logQ.size() < cnt) begin
      error_cnt++;
      test_done();
    end
    @(negedge clk_sys);
  endtask

  initial begin
    rst      <= 1'b1;
    regWrite <= 1'b0;
    memStall <= 1'b0;
    regAddr  <= 4'h0;
    regWdata <= 16'h0000;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values, read-back, refused writes
    rd(4'h0, 16'h0000);
    rd(4'h6, 16'h0001);
    for (k = 0; k < 7; k++) begin
      wr(regs[k], vals[k]);
      rd(regs[k], vals[k]);
    end
    wr(4'hf, 16'h1234);
    rd(4'hf, 16'h0000);
    wr(4'h6, 16'hffff);
    rd(4'h6, 16'h0001);
    $display("test registers done");
    // Periodic mode in a circular buffer crossing the bound
    wr(4'h1, 16'h0012);
    wr(4'h2, 16'h0040);
    wr(4'h3, 16'h0041);
    wr(4'h4, 16'h40fe);
    wr(4'h5, 16'h0003);
    wr(4'h9, 16'h0000);
    wr(4'h0, 16'h001b);
    far.push(8'h10);
    far.push(8'h11);
    waitLog(2);
    check(dmaIrq, 1'b0);
    far.push(8'h12);
    waitLog(3);
    check(dmaIrq, 1'b1);
    rd(4'h9, 16'h0001);
    wr(4'h9, 16'h0000);
    check(dmaIrq, 1'b0);
    far.push(8'h13);
    far.push(8'h14);
    waitLog(5);
    rd(4'h4, 16'h4003);
    for (k = 0; k < 5; k++) begin
      check(far.logQ[k], {8'h12, pa[k], 8'h10 + k[7:0]});
    end
    wr(4'h0, 16'h0018);
    @(negedge clk_sys);
    check({rxReady, memReq}, 2'b00);
    far.logQ.delete();
    $display("test periodic done");
    // No-interrupt mode, FIFO filled against a stalled memory
    wr(4'h4, 16'h0100);
    memStall <= 1'b1;
    wr(4'h0, 16'h0001);
    for (k = 0; k < 6; k++) far.push(8'h20 + k[7:0]);
    for (k = 0; k < 100 && far.sendQ.size() > 2; k++) @(posedge clk_sys);
    if (far.sendQ.size() > 2) begin
      error_cnt++;
      test_done();
    end
    repeat (2) @(posedge clk_sys);
    rd(4'h6, 16'h0022);
    rd(4'h7, 16'h0020);
    check(rxReady, 1'b0);
    memStall <= 1'b0;
    waitLog(6);
    for (k = 0; k < 6; k++) begin
      check(far.logQ[k], {8'h12, 8'h01, k[7:0], 8'h20 + k[7:0]});
    end
    rd(4'h6, 16'h0001);
    rd(4'h9, 16'h0000);
    check(dmaIrq, 1'b0);
    far.logQ.delete();
    $display("test fifo done");
    // Timeout mode, then masking by the enable bit
    wr(4'h8, 16'h0003);
    wr(4'h0, 16'h0015);
    far.push(8'h55);
    waitLog(1);
    check(dmaIrq, 1'b0);
    for (n = 0; n < 40 && dmaIrq !== 1'b1; n++) @(negedge clk_sys);
    if (n == 40) begin
      error_cnt++;
      test_done();
    end
    check(n >= 1 && n <= 12, 1'b1);
    rd(4'h9, 16'h0002);
    wr(4'h0, 16'h0005);
    check(dmaIrq, 1'b0);
    rd(4'h9, 16'h0002);
    wr(4'h0, 16'h0015);
    check(dmaIrq, 1'b1);
    $display("test timeout done");
    test_done();
  end
endmodule // uart_rx_dma_channel_bench
